// ==== common/iorm_pkg.sv ====
// Package for the I/O reference to register memory translator
package iorm_pkg;
    // ****************************************************
    // Widths
    // ****************************************************
    localparam int REG_W      = 16;          // Register word width
    localparam int ADDR_W     = 14;          // Zero-based index, 16K max
    localparam int POINT_W    = 10;          // Point number 0..1023
    localparam int CHAN_W     = 4;
    localparam int BIT_W      = 4;
    localparam int DEPTH      = 16384;

    // ****************************************************
    // Register numbers (one-based, as printed), word counts and first special point
    // ****************************************************
    localparam logic [ADDR_W:0] R_AUX_BASE     = 15'h0001; // R0001
    localparam logic [ADDR_W:0] R_MAIN_BASE    = 15'h0081; // R0129
    localparam logic [ADDR_W:0] R_MAIN_END     = 15'h0400; // R1024
    localparam logic [ADDR_W:0] R_AUXX_BASE    = 15'h0481; // R1153
    localparam logic [ADDR_W:0] R_AUXX_END     = 15'h0800; // R2048
    localparam logic [ADDR_W:0] R_INTM_BASE    = 15'h0801; // R2049
    localparam logic [ADDR_W:0] R_INTA_BASE    = 15'h0C01; // R3073
    localparam logic [ADDR_W:0] R_INTA_END     = 15'h1000; // R4096
    localparam logic [ADDR_W:0] R_BCS_BIG      = 15'h1001; // R4097
    localparam logic [ADDR_W:0] R_CLK_BIG      = 15'h1015; // R4117
    localparam logic [ADDR_W:0] R_FPTR_BIG     = 15'h1018; // R4120
    localparam logic [ADDR_W:0] R_BCS_1K       = 15'h0101; // R0257
    localparam logic [ADDR_W:0] R_CLK_1K       = 15'h010B; // R0267
    localparam logic [ADDR_W:0] R_FPTR_1K      = 15'h010E; // R0270
    localparam logic [ADDR_W:0] R_MBOX_1K      = 15'h03BB; // R0955
    localparam logic [ADDR_W:0] WORDS_PER_CHAN = 15'h0040; // 64 words
    localparam logic [ADDR_W:0] FAULT_ENTRY_W  = 15'h0004; // Per table
    localparam logic [ADDR_W:0] MBOX_WORDS     = 15'h0046; // 70 words
    localparam logic [POINT_W:0] SPECIAL_FIRST = 11'h3E9;  // Point 1001

    // ****************************************************
    // Register memory capacities
    // ****************************************************
    localparam logic [ADDR_W:0] CAP_256 = 15'h0100;
    localparam logic [ADDR_W:0] CAP_1K  = 15'h0400;
    localparam logic [ADDR_W:0] CAP_8K  = 15'h2000;
    localparam logic [ADDR_W:0] CAP_16K = 15'h4000;

    typedef enum logic [1:0] {
        SZ_256, SZ_1K, SZ_8K, SZ_16K
    } iorm_size_t;

    typedef enum logic [1:0] {
        AREA_REAL, AREA_INTERNAL, AREA_SYSTEM, AREA_REGISTER
    } iorm_area_t;

    typedef enum logic [2:0] {
        SYS_BCS, SYS_CLOCK, SYS_FPTR, SYS_FAULT, SYS_MBOX
    } iorm_sys_t;

    // One program access request
    typedef struct packed {
        iorm_area_t         area;
        logic               output_sel;  // Output half of channel
        logic [CHAN_W-1:0]  chan;
        logic [POINT_W-1:0] point;       // Point number minus one
        iorm_sys_t          sys;
        logic [ADDR_W-1:0]  index;       // Register number minus one
        logic               isWrite;
        logic               bitOp;       // Single bit access
        logic [REG_W-1:0]   wdata;
    } iorm_req_t;

    // Answer to a request
    typedef struct packed {
        logic [REG_W-1:0]  rdata;
        logic              bitVal;
        logic [ADDR_W-1:0] index;
        logic [BIT_W-1:0]  bitPos;
        logic              err;
    } iorm_rsp_t;
endpackage : iorm_pkg

// ==== design/iorm_mem.sv ====
// Register memory array with registered read data
`timescale 1ns/100ps
module iorm_mem (
    input  wire logic                          clk,
    input  wire logic                          we,
    input  wire logic [iorm_pkg::ADDR_W-1:0]   addr,
    input  wire logic [iorm_pkg::REG_W-1:0]    wdata,
    output logic      [iorm_pkg::REG_W-1:0]    rdata
);
    logic [iorm_pkg::REG_W-1:0] mem [iorm_pkg::DEPTH];

    // ****************************************************
    // Storage
    // ****************************************************
    // No reset: contents are user data, read is write-first-ignored
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule : iorm_mem

// ==== design/iorm_translator.sv ====
// Translates discrete I/O references into register memory accesses
// Overview of operation
// - Channel 0 real points live in main status table, not registers.
// - Channel 8 real points live in R0001 to R0128.
// - Main channels 1-7 real points map from R0129 to R1024.
// - Aux channels 9-F real points map to R1153 to R2048.
// - Internal references of channels 0-7 map to R2049 to R3072.
// - Internal references of channels 8-F map to R3073 to R4096.
// - Each register is 16 bits, accessed as word or single bit.
// - Register memory size selectable as 256, 1K, 8K or 16K.
// - 8K/16K: bus status R4097, clock R4117, fault pointer R4120.
// - 1K: channels 8 and 1 only; status R0257, clock R0267, R0270.
// - Overlaid registers remain plain storage when references unused.
// - Free registers after fault table shrink with fault table count.
// - Each channel half is 64 words; points 1001-1024 reserved.
`timescale 1ns/100ps
module iorm_translator (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire iorm_pkg::iorm_size_t  sizeSel,
    input  wire logic [3:0]            faultTables,
    input  wire logic                  reqValid,
    input  wire iorm_pkg::iorm_req_t   req,
    output logic                       reqReady,
    output logic                       mainTableSel,
    output logic                       rspValid,
    output iorm_pkg::iorm_rsp_t        rsp,
    output logic [iorm_pkg::ADDR_W:0]  userFreeLast
);
    localparam int AW = iorm_pkg::ADDR_W;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} iorm_state_t;

    iorm_state_t                state_reg, state_next;
    iorm_pkg::iorm_req_t        hold_reg;
    logic [AW-1:0]              index_reg;
    logic [iorm_pkg::BIT_W-1:0] bitPos_reg;
    logic                       err_reg;
    logic                       mainSel_reg;
    logic                       rspValid_reg;
    logic [iorm_pkg::REG_W-1:0] memRdata;

    // ****************************************************
    // Capacity of the configured size
    // ****************************************************
    function automatic logic [AW:0] capOf(iorm_pkg::iorm_size_t s);
        unique case (s)
            iorm_pkg::SZ_256: capOf = iorm_pkg::CAP_256;
            iorm_pkg::SZ_1K:  capOf = iorm_pkg::CAP_1K;
            iorm_pkg::SZ_8K:  capOf = iorm_pkg::CAP_8K;
            iorm_pkg::SZ_16K: capOf = iorm_pkg::CAP_16K;
        endcase
    endfunction : capOf

    // Base of a real channel, zero-based; out-of-map returns all ones
    function automatic logic [AW:0] realBase(logic [3:0] ch, logic big);
        logic [AW:0] off;
        off = iorm_pkg::WORDS_PER_CHAN * 15'({ch[2:0], 1'b0});
        if (ch == 4'h8) begin
            realBase = iorm_pkg::R_AUX_BASE - 15'h0001;
        end else if (!ch[3] && big) begin
            realBase = iorm_pkg::R_MAIN_BASE - 15'h0001
                       + off - iorm_pkg::WORDS_PER_CHAN * 15'h0002;
        end else if (ch[3] && big) begin
            realBase = iorm_pkg::R_AUXX_BASE - 15'h0001
                       + off - iorm_pkg::WORDS_PER_CHAN * 15'h0002;
        end else if (ch == 4'h1) begin
            realBase = iorm_pkg::R_MAIN_BASE - 15'h0001;
        end else begin
            realBase = '1;
        end
    endfunction : realBase

    // ****************************************************
    // Address decode
    // ****************************************************
    wire logic [AW:0] cap      = capOf(sizeSel);
    wire logic        bigMap   = (sizeSel == iorm_pkg::SZ_8K) ||
                                 (sizeSel == iorm_pkg::SZ_16K);
    wire logic        oneK     = (sizeSel == iorm_pkg::SZ_1K);
    wire logic [AW:0] halfOff  = req.output_sel ? '0 :
                                 iorm_pkg::WORDS_PER_CHAN;
    wire logic [AW:0] pointWd  = 15'(req.point >> iorm_pkg::BIT_W);
    wire logic [AW:0] rBase    = realBase(req.chan, bigMap);
    wire logic [AW:0] intBase  = (req.chan[3] ? iorm_pkg::R_INTA_BASE
                                 : iorm_pkg::R_INTM_BASE) - 15'h0001
                                 + iorm_pkg::WORDS_PER_CHAN
                                 * 15'({req.chan[2:0], 1'b0});
    wire logic [AW:0] faultEnd = (bigMap ? iorm_pkg::R_FPTR_BIG
                                 : iorm_pkg::R_FPTR_1K)
                                 + iorm_pkg::FAULT_ENTRY_W
                                 * 15'(faultTables);
    wire logic [AW:0] mboxBase = oneK ? iorm_pkg::R_MBOX_1K
                                 : cap - iorm_pkg::MBOX_WORDS + 15'h0001;
    logic [AW:0] sysReg;
    always_comb begin
        unique case (req.sys)
            iorm_pkg::SYS_BCS:   sysReg = bigMap ? iorm_pkg::R_BCS_BIG
                                                 : iorm_pkg::R_BCS_1K;
            iorm_pkg::SYS_CLOCK: sysReg = bigMap ? iorm_pkg::R_CLK_BIG
                                                 : iorm_pkg::R_CLK_1K;
            iorm_pkg::SYS_FPTR:  sysReg = bigMap ? iorm_pkg::R_FPTR_BIG
                                                 : iorm_pkg::R_FPTR_1K;
            iorm_pkg::SYS_FAULT: sysReg = (bigMap ? iorm_pkg::R_FPTR_BIG
                                 : iorm_pkg::R_FPTR_1K) + 15'h0001;
            iorm_pkg::SYS_MBOX:  sysReg = mboxBase;
            default:             sysReg = '1;
        endcase
    end

    // Full zero-based index before the capacity check
    logic [AW:0] fullIdx;
    always_comb begin
        unique case (req.area)
            iorm_pkg::AREA_REAL:     fullIdx = rBase + halfOff + pointWd;
            iorm_pkg::AREA_INTERNAL: fullIdx = intBase + halfOff + pointWd;
            iorm_pkg::AREA_SYSTEM:   fullIdx = sysReg - 15'h0001;
            iorm_pkg::AREA_REGISTER: fullIdx = {1'b0, req.index};
        endcase
    end

    // Channel 0 real goes to the main status table, no memory touched
    wire logic chan0Real = (req.area == iorm_pkg::AREA_REAL) &&
                           (req.chan == 4'h0);
    // Real channels outside this size's map are refused, never wrapped
    wire logic realOff   = (req.area == iorm_pkg::AREA_REAL) && (&rBase);
    // Internal area needs the large maps; system area absent at 256
    wire logic areaBad   = ((req.area == iorm_pkg::AREA_INTERNAL) && !bigMap)
                           || ((req.area == iorm_pkg::AREA_SYSTEM) &&
                               (sizeSel == iorm_pkg::SZ_256))
                           || realOff;
    wire logic reqErr    = !chan0Real && (areaBad || (fullIdx >= cap));
    wire logic accept    = reqValid && (state_reg == ST_IDLE);

    // ****************************************************
    // Sequencer: one request at a time
    // ****************************************************
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:  if (accept && !reqErr && !chan0Real) begin
                state_next = (req.isWrite && !req.bitOp) ? ST_WRITE : ST_READ;
            end
            ST_READ:  state_next = (hold_reg.isWrite) ? ST_WRITE : ST_IDLE;
            ST_WRITE: state_next = ST_IDLE;
            default:  state_next = ST_IDLE;
        endcase
    end

    assign reqReady = (state_reg == ST_IDLE);

    // Bit writes are read-modify-write so neighbours survive
    wire logic [iorm_pkg::REG_W-1:0] bitMask = 16'h0001 << bitPos_reg;
    wire logic [iorm_pkg::REG_W-1:0] memWdata = hold_reg.bitOp ?
        ((memRdata & ~bitMask) | (hold_reg.wdata[0] ? bitMask : '0))
        : hold_reg.wdata;
    wire logic memWe = (state_reg == ST_WRITE);
    wire logic [AW-1:0] memAddr = (state_reg == ST_IDLE)
                                  ? fullIdx[AW-1:0] : index_reg;

    iorm_mem iorm_mem_i (
        .clk   (clk),
        .we    (memWe),
        .addr  (memAddr),
        .wdata (memWdata),
        .rdata (memRdata)
    );

    // ****************************************************
    // Request capture
    // ****************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg   <= ST_IDLE;
            hold_reg    <= '0;
            index_reg   <= '0;
            bitPos_reg  <= '0;
            err_reg     <= 1'b0;
            mainSel_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (accept) begin
                hold_reg    <= req;
                index_reg   <= fullIdx[AW-1:0];
                bitPos_reg  <= req.point[iorm_pkg::BIT_W-1:0];
                err_reg     <= reqErr;
                mainSel_reg <= chan0Real;
            end
        end
    end

    // ****************************************************
    // Answer
    // ****************************************************
    // Answer one cycle after acceptance for instant cases, else at end
    wire logic done = (accept && (reqErr || chan0Real)) ||
                      (state_reg == ST_READ && !hold_reg.isWrite) ||
                      (state_reg == ST_WRITE);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rspValid_reg <= 1'b0;
            rsp          <= '0;
        end else begin
            rspValid_reg <= done;
            if (done) begin
                rsp.index  <= accept ? fullIdx[AW-1:0] : index_reg;
                rsp.bitPos <= accept ? req.point[iorm_pkg::BIT_W-1:0]
                                     : bitPos_reg;
                rsp.err    <= accept ? reqErr : err_reg;
                rsp.rdata  <= accept ? '0 : memRdata;
                rsp.bitVal <= accept ? 1'b0 : memRdata[bitPos_reg];
            end
        end
    end

    assign rspValid     = rspValid_reg;
    assign mainTableSel = mainSel_reg;
    assign userFreeLast = mboxBase - 15'h0001 - faultEnd;
endmodule : iorm_translator

// ==== dv/iorm_partner.sv ====
// Program-side requester feeding references to the translator
`timescale 1ns/100ps
module iorm_partner (
    input  wire logic                clk,
    input  wire logic                reqReady,
    input  wire logic                rspValid,
    input  wire iorm_pkg::iorm_rsp_t rsp,
    output iorm_pkg::iorm_req_t      req,
    output logic                     reqValid
);
    // Idle at time zero
    initial begin
        reqValid = 1'b0;
        req = '0;
    end

    // One transfer, held until taken or 17 edges pass; answer awaited a bounded time
    task automatic access(input iorm_pkg::iorm_req_t r,
                          output iorm_pkg::iorm_rsp_t a, output bit ok);
        int n;
        ok = 1'b0;
        a = '0;
        req = r;
        reqValid = 1'b1;
        for (n = 0; n < 16 && !reqReady; n++) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        reqValid = 1'b0;
        req = ~r; // Released lines never show stale data
        for (n = 0; n < 8 && !ok; n++) begin
            if (rspValid) begin
                a = rsp;
                ok = 1'b1;
            end else begin
                @(posedge clk);
                #1;
            end
        end
        // Let an edge pass so a next call never re-raises in this step
        @(posedge clk);
        #1;
    endtask : access
endmodule : iorm_partner

// ==== dv/iorm_properties.sv ====
// Port-level timing and address checks for the translator
`timescale 1ns/100ps
module iorm_properties (
    input wire logic                      clk,
    input wire logic                      rst,
    input wire iorm_pkg::iorm_size_t      sizeSel,
    input wire logic [3:0]                faultTables,
    input wire logic                      reqValid,
    input wire iorm_pkg::iorm_req_t       req,
    input wire logic                      reqReady,
    input wire logic                      mainTableSel,
    input wire logic                      rspValid,
    input wire iorm_pkg::iorm_rsp_t       rsp,
    input wire logic [iorm_pkg::ADDR_W:0] userFreeLast
);
    // ****************************************************
    // Decodes of the accepted request
    // ****************************************************
    wire acc = reqValid & reqReady;
    wire big = sizeSel[1];
    wire full = sizeSel == iorm_pkg::SZ_16K;
    wire rd = acc & ~req.isWrite;
    wire inReg = req.area == iorm_pkg::AREA_REGISTER;
    wire inSys = req.area == iorm_pkg::AREA_SYSTEM && req.index == 14'h0000;
    wire isReal = req.area == iorm_pkg::AREA_REAL;
    wire mapped = req.area == iorm_pkg::AREA_INTERNAL | isReal & |req.chan;

    // 128 words per channel; channel 8 real folds down to the bottom
    function automatic logic [17:0] expLoc(iorm_pkg::iorm_req_t r);
        logic [13:0] ix;
        ix = {3'h0, r.chan, 7'h00} + {7'h00, ~r.output_sel, 6'h00};
        ix = ix + {8'h00, r.point[9:4]};
        if (r.area == iorm_pkg::AREA_INTERNAL) begin
            ix = ix + 14'h0800;
        end else if (r.chan == 4'h8) begin
            ix = ix - 14'h0400;
        end
        return {ix, r.point[3:0]};
    endfunction : expLoc

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    map_loc_a: assert property (
        rd && big && mapped |->
        ##2 {rsp.index, rsp.bitPos} == expLoc($past(req, 2)))
        else $error("mapped index or bit wrong");
    main_table_a: assert property (
        acc && big && isReal && req.chan == 4'h0 |=>
        rspValid && mainTableSel && !rsp.err)
        else $error("channel 0 not sent to main table");
    int_small_a: assert property (
        acc && !big && req.area == iorm_pkg::AREA_INTERNAL |=>
        rspValid && rsp.err) else $error("internal area not refused");
    cap_small_a: assert property (
        acc && inReg && sizeSel == iorm_pkg::SZ_256 && |req.index[13:8]
        |=> rspValid && rsp.err) else $error("index over capacity taken");
    read_lat_a: assert property (
        rd && full && inReg |=> !rspValid ##1 rspValid && !rsp.err)
        else $error("word read latency wrong");
    bit_wr_a: assert property (
        acc && full && (inReg | mapped) && req.isWrite && req.bitOp |=>
        !rspValid[*2] ##1 rspValid) else $error("bit write latency wrong");
    busy_ready_a: assert property (
        acc && full && inReg |=> !reqReady)
        else $error("request taken while busy");
    real_small_a: assert property (
        acc && sizeSel == iorm_pkg::SZ_1K && isReal && req.chan != 4'h0 &&
        req.chan != 4'h1 && req.chan != 4'h8 |=> rspValid && rsp.err)
        else $error("unmapped real channel taken");
    clock_big_a: assert property (
        rd && big && inSys && req.sys == iorm_pkg::SYS_CLOCK |->
        ##2 rsp.index == 14'h1014) else $error("clock misplaced");
    fptr_small_a: assert property (
        rd && sizeSel == iorm_pkg::SZ_1K && inSys &&
        req.sys == iorm_pkg::SYS_FPTR |-> ##2 rsp.index == 14'h010D)
        else $error("fault pointer misplaced");
    fault_shrink_a: assert property (
        faultTables == $past(faultTables) + 4'h1 && faultTables != 4'h0 &&
        $stable(sizeSel) |->
        userFreeLast == $past(userFreeLast) - 15'h0004)
        else $error("free registers did not shrink");

    cover property (acc && req.isWrite && req.bitOp);
    cover property (rspValid && rsp.err);
    cover property (rspValid && mainTableSel);
endmodule : iorm_properties

bind iorm_translator iorm_properties iorm_properties_i (.clk(clk),
    .rst(rst), .sizeSel(sizeSel), .faultTables(faultTables),
    .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .mainTableSel(mainTableSel), .rspValid(rspValid), .rsp(rsp),
    .userFreeLast(userFreeLast));

// ==== dv/io_reference_register_map_tb.sv ====
// Self-checking bench for the I/O reference register map
`timescale 1ns/100ps
module io_reference_register_map_tb;
    // ****************************************************
    // Bench signals and shared tasks
    // ****************************************************
    logic                      clk;
    logic                      rst;
    iorm_pkg::iorm_size_t      sizeSel;
    logic [3:0]                faultTables;
    logic                      reqValid;
    iorm_pkg::iorm_req_t       req;
    logic                      reqReady;
    logic                      mainTableSel;
    logic                      rspValid;
    iorm_pkg::iorm_rsp_t       rsp;
    logic [iorm_pkg::ADDR_W:0] userFreeLast;
    iorm_pkg::iorm_rsp_t       a;
    int                        errorCnt = 0;
    int                        nCompared = 0;
    int                        cycles = 0;

    iorm_translator iorm_translator_i (.clk(clk), .rst(rst),
        .sizeSel(sizeSel), .faultTables(faultTables), .reqValid(reqValid),
        .req(req), .reqReady(reqReady), .mainTableSel(mainTableSel),
        .rspValid(rspValid), .rsp(rsp), .userFreeLast(userFreeLast));
    iorm_partner iorm_partner_i (.clk(clk), .reqReady(reqReady),
        .rspValid(rspValid), .rsp(rsp), .req(req), .reqValid(reqValid));

    // Clock at 4 ns; the 5000-cycle ceiling is over forty times the expected run
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errorCnt++;
            endOfTest();
        end
    end

    task automatic endOfTest();
        $display("compared %0d mismatches %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : endOfTest

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        nCompared++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            errorCnt++;
        end
    endtask : chk

    // For system requests the channel argument carries the system register code
    task automatic go(iorm_pkg::iorm_area_t ar, logic [3:0] c, logic o,
                      logic [9:0] p, logic [13:0] ix, logic [1:0] op,
                      logic [15:0] d);
        bit ok;
        iorm_partner_i.access('{area: ar, output_sel: o, chan: c,
            point: p, sys: iorm_pkg::iorm_sys_t'(c[2:0]), index: ix,
            isWrite: op[1], bitOp: op[0], wdata: d}, a, ok);
        chk("answer", 16'h0001, {15'h0000, ok});
    endtask : go

    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic realMap();
        int ch[5] = '{1, 7, 8, 9, 15};
        int e;
        sizeSel = iorm_pkg::SZ_16K;
        foreach (ch[i]) begin
            for (int o = 0; o < 2; o++) begin
                e = (ch[i] == 8 ? 0 : ch[i] * 128) + (o == 1 ? 62 : 126);
                go(iorm_pkg::AREA_REAL, ch[i][3:0], o[0], 10'h3E7,
                   14'h0000, 2'b00, 16'h0000);
                chk("real index", e[15:0], {2'b00, a.index});
                chk("bit", 16'h0007, {12'h000, a.bitPos});
            end
        end
        go(iorm_pkg::AREA_REAL, 4'h0, 1'b1, 10'h005, 14'h0000, 2'b00, 16'h0);
        chk("main table", 16'h0001, {15'h0000, mainTableSel});
    endtask : realMap

    task automatic internalMap();
        int ch[3] = '{0, 8, 15};
        sizeSel = iorm_pkg::SZ_8K;
        foreach (ch[i]) begin
            go(iorm_pkg::AREA_INTERNAL, ch[i][3:0], 1'b1, 10'h000,
               14'h0000, 2'b00, 16'h0000);
            chk("internal", 16'(2048 + ch[i] * 128), {2'b00, a.index});
        end
        sizeSel = iorm_pkg::SZ_1K;
        go(iorm_pkg::AREA_INTERNAL, 4'h0, 1'b1, 10'h0, 14'h0, 2'b00, 16'h0);
        chk("internal at 1K", 16'h0001, {15'h0000, a.err});
        go(iorm_pkg::AREA_REAL, 4'h8, 1'b0, 10'h010, 14'h0, 2'b00, 16'h0);
        chk("chan 8 at 1K", 16'h0041, {2'b00, a.index});
        go(iorm_pkg::AREA_REAL, 4'h3, 1'b1, 10'h010, 14'h0, 2'b00, 16'h0);
        chk("chan 3 at 1K", 16'h0001, {15'h0000, a.err});
    endtask : internalMap

    task automatic systemMap();
        logic [15:0] e[10] = '{16'h1000, 16'h1014, 16'h1017, 16'h3FBA,
                               16'h1018, 16'h0100, 16'h010A, 16'h010D,
                               16'h03BA, 16'h010E};
        int s[5] = '{0, 1, 2, 4, 3};
        for (int k = 0; k < 10; k++) begin
            sizeSel = k < 5 ? iorm_pkg::SZ_16K : iorm_pkg::SZ_1K;
            go(iorm_pkg::AREA_SYSTEM, 4'(s[k % 5]), 1'b0, 10'h0, 14'h0,
               2'b00, 16'h0);
            chk("system index", e[k], {2'b00, a.index});
        end
    endtask : systemMap

    task automatic storage();
        sizeSel = iorm_pkg::SZ_16K;
        go(iorm_pkg::AREA_REGISTER, 4'h0, 1'b0, 10'h0, 14'h0200, 2'b10,
           16'hA5C3);
        go(iorm_pkg::AREA_REAL, 4'h4, 1'b1, 10'h000, 14'h0, 2'b01, 16'h0);
        chk("overlaid word", 16'hA5C3, a.rdata);
        chk("bit value", 16'h0001, {15'h0000, a.bitVal});
        go(iorm_pkg::AREA_REAL, 4'h4, 1'b1, 10'h002, 14'h0, 2'b11, 16'h1);
        go(iorm_pkg::AREA_REGISTER, 4'h0, 1'b0, 10'h0, 14'h0200, 2'b00,
           16'h0);
        chk("after bit write", 16'hA5C7, a.rdata);
    endtask : storage

    task automatic capacity();
        sizeSel = iorm_pkg::SZ_256;
        go(iorm_pkg::AREA_REGISTER, 4'h0, 1'b0, 10'h0, 14'h00FF, 2'b10,
           16'h1234);
        go(iorm_pkg::AREA_REGISTER, 4'h0, 1'b0, 10'h0, 14'h00FF, 2'b00,
           16'h0);
        chk("top of 256", 16'h1234, a.rdata);
        go(iorm_pkg::AREA_REGISTER, 4'h0, 1'b0, 10'h0, 14'h0100, 2'b00,
           16'h0);
        chk("over 256", 16'h0001, {15'h0000, a.err});
    endtask : capacity

    // Mid-run reset: port idle at once, memory contents kept
    task automatic midReset();
        rst = 1'b1;
        @(posedge clk);
        #1;
        chk("ready in reset", 16'h0001, {15'h0000, reqReady});
        chk("valid in reset", 16'h0000, {15'h0000, rspValid});
        rst = 1'b0;
        go(iorm_pkg::AREA_REGISTER, 4'h0, 1'b0, 10'h0, 14'h00FF, 2'b00,
           16'h0);
        chk("kept over reset", 16'h1234, a.rdata);
    endtask : midReset

    // Faults only at 1K, since the smallest size lacks them
    task automatic faultArea();
        logic [14:0] u0;
        sizeSel = iorm_pkg::SZ_1K;
        @(posedge clk);
        #1;
        u0 = userFreeLast;
        for (int t = 1; t < 4; t++) begin
            faultTables = 4'(t);
            @(posedge clk);
            #1;
            u0 = u0 - 15'h0004;
            chk("free regs", {1'b0, u0}, {1'b0, userFreeLast});
        end
    endtask : faultArea

    // Reset for five cycles, then every scenario in turn
    initial begin
        rst = 1'b1;
        sizeSel = iorm_pkg::SZ_16K;
        faultTables = 4'h0;
        repeat (5) @(posedge clk);
        #1;
        rst = 1'b0;
        realMap();
        internalMap();
        systemMap();
        storage();
        capacity();
        midReset();
        faultArea();
        endOfTest();
    end
endmodule : io_reference_register_map_tb
